//--- hdl/rcr_params.svh
// Constants for the reset cause capture and debug forced reset block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef RCR_PARAMS_SVH
`define RCR_PARAMS_SVH

// Clock period and reset pulse timing
`define RCR_CLK_NS 40
`define RCR_HOLD_NS 400
`define RCR_HOLD_CYC ((`RCR_HOLD_NS + `RCR_CLK_NS - 1) / `RCR_CLK_NS)

// Register offsets on the local register port
`define RCR_OFF_STATUS 8'h00
`define RCR_OFF_FORCE 8'h01

// Field positions in the cause register
`define RCR_BIT_POR 7
`define RCR_BIT_PIN 6
`define RCR_BIT_WDOG 5
`define RCR_BIT_ILLEGAL_OPCODE_FLAG 4
`define RCR_BIT_ILLEGAL_ADDRESS_FLAG 3
`define RCR_BIT_LVD 1
`define RCR_BIT_FORCE 0

// Values
`define RCR_POR_FLAGS 8'h82
`define RCR_ZERO_BYTE 8'h00

`endif

//--- hdl/rcr_pkg.sv
// Types shared by the reset cause block.
// Assumes the constants header sits beside it.
`include "rcr_params.svh"

package rcr_pkg;
    typedef logic [7:0] byte_t;          // One register byte
    typedef enum {
        ST_RUN,                           // Normal operation
        ST_HOLD                           // Chip reset asserted
    } seq_state_e;
endpackage

//--- hdl/rcr_cause_if.sv
// Carrier between the sequencer and the cause flag store.
// Assumes both ends share sys_clk.
interface rcr_cause_if;
    import rcr_pkg::*;
    logic clear_all;       // Forced reset: wipe every flag
    logic capture_lvd;     // Low-voltage reset entry
    logic capture_any;     // Other reset entry
    logic pin_src;         // Reset pin active at entry
    logic wdog_src;        // Watchdog timeout at entry
    logic illegal_opcode_flag_src;        // Illegal opcode at entry
    logic illegal_address_flag_src;        // Illegal address at entry
    byte_t flags;          // Stored cause flags
    modport seq (output clear_all, capture_lvd, capture_any, pin_src, wdog_src,
        illegal_opcode_flag_src, illegal_address_flag_src, input flags);
    modport store (input clear_all, capture_lvd, capture_any, pin_src, wdog_src,
        illegal_opcode_flag_src, illegal_address_flag_src, output flags);
endinterface

//--- hdl/rcr_cause_store.sv
// Holds the reset cause flags and updates them only at reset entry.
// Assumes capture strobes are one-cycle pulses from the sequencer.
`include "rcr_params.svh"

module rcr_cause_store
    import rcr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    rcr_cause_if.store cause
);
    byte_t flags_reg;   // Stored flags
    byte_t flags_next;  // Next flags

    ////////////////////////////////////////////////////////////////////////////
    // Next flag value: only the three entry strobes can change it
    always_comb begin
        flags_next = flags_reg;
        if (cause.clear_all) begin
            flags_next = `RCR_ZERO_BYTE;
        end else if (cause.capture_lvd) begin
            // Power-on flag kept, low-voltage set, rest cleared
            flags_next = `RCR_ZERO_BYTE;
            flags_next[`RCR_BIT_POR] = flags_reg[`RCR_BIT_POR];
            flags_next[`RCR_BIT_LVD] = 1'b1;
        end else if (cause.capture_any) begin
            // Each source flag follows its source at entry
            flags_next = `RCR_ZERO_BYTE;
            flags_next[`RCR_BIT_PIN] = cause.pin_src;
            flags_next[`RCR_BIT_WDOG] = cause.wdog_src;
            flags_next[`RCR_BIT_ILLEGAL_OPCODE_FLAG] = cause.illegal_opcode_flag_src;
            flags_next[`RCR_BIT_ILLEGAL_ADDRESS_FLAG] = cause.illegal_address_flag_src;
        end
    end

    // Register; the block's own reset is the power-on event
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            flags_reg <= `RCR_POR_FLAGS;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign cause.flags = flags_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_flags_hold: assert property (@(posedge sys_clk) disable iff (reset)
        !(cause.clear_all || cause.capture_lvd || cause.capture_any)
        |=> $stable(flags_reg))
        else $error("cause flags changed outside reset entry");
    a_lvd_keeps_por: assert property (@(posedge sys_clk) disable iff (reset)
        cause.capture_lvd && !cause.clear_all
        |=> flags_reg[`RCR_BIT_LVD] && flags_reg[`RCR_BIT_POR] == $past(flags_reg[`RCR_BIT_POR]))
        else $error("low-voltage entry flags wrong");
    a_other_clears: assert property (@(posedge sys_clk) disable iff (reset)
        cause.capture_any && !cause.capture_lvd && !cause.clear_all
        |=> !flags_reg[`RCR_BIT_POR] && !flags_reg[`RCR_BIT_LVD]
            && flags_reg[`RCR_BIT_WDOG] == $past(cause.wdog_src))
        else $error("other reset entry flags wrong");
endmodule

//--- hdl/rcr_top.sv
// Reset cause capture and debug forced reset sequencer.
// Assumes sources arrive from logic on sys_clk except the two pins.
`include "rcr_params.svh"

module rcr_top
    import rcr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic reg_wr_debug,
    input wire logic [7:0] reg_addr,
    input wire rcr_pkg::byte_t reg_wr_data,
    output logic [7:0] reg_rd_data,
    input wire logic reset_pin_n,
    input wire logic low_voltage_trip,
    input wire logic low_voltage_reset_enable,
    input wire logic watchdog_timeout,
    input wire logic watchdog_enable,
    input wire logic illegal_opcode_exec,
    input wire logic stop_exec,
    input wire logic stop_enable,
    input wire logic background_entry_instruction,
    input wire logic background_mode_enable,
    input wire logic illegal_address_access,
    input wire logic background_mode_select_pin,
    output logic system_reset,
    output logic watchdog_restart,
    output logic debug_halt_mode
);
    import rcr_pkg::*;

    // Address match, shared by read and write decode
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
        addr_hit = (addr == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: bit 0 reset pin, bit 1 mode pin
    logic [1:0] pin_meta_reg;  // First stage, read only by the second
    logic [1:0] pin_sync_reg;  // Second stage, safe to use
    logic [1:0] pin_raw;
    assign pin_raw = {background_mode_select_pin, reset_pin_n};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            // Pins idle high, so reset to the inactive level
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    pin_meta_reg[gi] <= 1'b1;
                    pin_sync_reg[gi] <= 1'b1;
                end else begin
                    pin_meta_reg[gi] <= pin_raw[gi];
                    pin_sync_reg[gi] <= pin_meta_reg[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Source decode
    logic pin_now;    // Reset pin held low
    logic wdog_now;   // Watchdog timeout while enabled
    logic illegal_opcode_flag_now;   // Any illegal opcode form
    logic lvd_now;    // Low-voltage trip with reset enabled
    logic force_now;  // Debug write of one to the forced reset bit
    logic any_now;    // Any non-forced source except low voltage

    assign pin_now = ~pin_sync_reg[0];
    assign wdog_now = watchdog_timeout & watchdog_enable;
    // Stop and background entry count as illegal when disabled
    assign illegal_opcode_flag_now = illegal_opcode_exec | (stop_exec & ~stop_enable)
        | (background_entry_instruction & ~background_mode_enable);
    assign lvd_now = low_voltage_trip & low_voltage_reset_enable;
    // User program writes are dropped here, not merely masked later
    assign force_now = reg_wr_en & reg_wr_debug & addr_hit(reg_addr, `RCR_OFF_FORCE)
        & reg_wr_data[`RCR_BIT_FORCE];
    assign any_now = pin_now | wdog_now | illegal_opcode_flag_now | illegal_address_access;

    ////////////////////////////////////////////////////////////////////////////
    // Cause store
    rcr_cause_if cause ();

    rcr_cause_store u_store (
        .sys_clk(sys_clk),
        .reset(reset),
        .cause(cause)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencer
    seq_state_e state_reg;     // Run or hold
    seq_state_e state_next;
    logic [7:0] hold_cnt_reg;  // Remaining reset pulse cycles
    logic [7:0] hold_cnt_next;
    logic forced_reg;          // Current reset came from the debug host
    logic forced_next;
    logic debug_mode_reg;      // Debug halt mode selected
    logic debug_mode_next;

    // Next state; forced reset outranks low-voltage, which outranks the rest
    always_comb begin
        state_next = state_reg;
        hold_cnt_next = hold_cnt_reg;
        forced_next = forced_reg;
        debug_mode_next = debug_mode_reg;
        cause.clear_all = 1'b0;
        cause.capture_lvd = 1'b0;
        cause.capture_any = 1'b0;
        case (state_reg)
            ST_RUN: begin
                if (force_now || lvd_now || any_now) begin
                    state_next = ST_HOLD;
                    hold_cnt_next = 8'(`RCR_HOLD_CYC - 1);
                    forced_next = force_now;
                    cause.clear_all = force_now;
                    cause.capture_lvd = !force_now && lvd_now;
                    cause.capture_any = !force_now && !lvd_now;
                end
            end
            ST_HOLD: begin
                if (hold_cnt_reg != 8'h00) begin
                    hold_cnt_next = hold_cnt_reg - 8'h01;
                end else if (!lvd_now && !pin_now) begin
                    // Stay held while supply is low or the pin is still low
                    state_next = ST_RUN;
                    if (forced_reg) begin
                        debug_mode_next = ~pin_sync_reg[1];
                    end
                    forced_next = 1'b0;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= ST_RUN;
            hold_cnt_reg <= 8'h00;
            forced_reg <= 1'b0;
            debug_mode_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            hold_cnt_reg <= hold_cnt_next;
            forced_reg <= forced_next;
            debug_mode_reg <= debug_mode_next;
        end
    end

    // Source levels sampled at entry; the store only uses them on capture
    assign cause.pin_src = pin_now;
    assign cause.wdog_src = wdog_now;
    assign cause.illegal_opcode_flag_src = illegal_opcode_flag_now;
    assign cause.illegal_address_flag_src = illegal_address_access;

    ////////////////////////////////////////////////////////////////////////////
    // Register port: reads answer one cycle later from a register
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic wd_restart_reg;
    logic wd_restart_next;

    always_comb begin
        rd_data_next = `RCR_ZERO_BYTE;
        if (reg_rd_en && addr_hit(reg_addr, `RCR_OFF_STATUS)) begin
            rd_data_next = cause.flags;
        end
        // Data value is irrelevant; the write never reaches the flags
        wd_restart_next = reg_wr_en && addr_hit(reg_addr, `RCR_OFF_STATUS)
            && (state_reg == ST_RUN);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rd_data_reg <= `RCR_ZERO_BYTE;
            wd_restart_reg <= 1'b0;
        end else begin
            rd_data_reg <= rd_data_next;
            wd_restart_reg <= wd_restart_next;
        end
    end

    assign reg_rd_data = rd_data_reg;
    assign watchdog_restart = wd_restart_reg;
    assign system_reset = (state_reg == ST_HOLD);
    assign debug_halt_mode = debug_mode_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_force_reads_zero: assert property (@(posedge sys_clk) disable iff (reset)
        reg_rd_en && addr_hit(reg_addr, `RCR_OFF_FORCE) |=> reg_rd_data == `RCR_ZERO_BYTE)
        else $error("forced reset register read not zero");
    a_write_restarts_wd: assert property (@(posedge sys_clk) disable iff (reset)
        reg_wr_en && addr_hit(reg_addr, `RCR_OFF_STATUS) && !system_reset
        |=> watchdog_restart)
        else $error("status write did not restart watchdog");
    a_write_keeps_flags: assert property (@(posedge sys_clk) disable iff (reset)
        reg_wr_en && addr_hit(reg_addr, `RCR_OFF_STATUS) && !system_reset && !force_now
        && !lvd_now && !any_now |=> $stable(cause.flags))
        else $error("status write altered flags");
    // Helper for the pulse length check: edges at which the chip reset has stood
    logic [7:0] hold_seen_reg;
    logic [7:0] hold_seen_next;

    // Count while the chip reset stands, restart from zero once it drops
    always_comb begin
        hold_seen_next = 8'h00;
        if (system_reset) begin
            // Saturate so a long pin or supply hold cannot wrap the count
            hold_seen_next = (hold_seen_reg == 8'hff) ? hold_seen_reg : hold_seen_reg + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hold_seen_reg <= 8'h00;
        end else begin
            hold_seen_reg <= hold_seen_next;
        end
    end

    a_force_resets: assert property (@(posedge sys_clk) disable iff (reset)
        force_now && !system_reset |=> system_reset)
        else $error("forced reset did not start");
    a_hold_length: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(system_reset) |-> hold_seen_reg >= 8'(`RCR_HOLD_CYC))
        else $error("chip reset pulse too short");
    a_force_clears: assert property (@(posedge sys_clk) disable iff (reset)
        force_now && !system_reset |=> cause.flags == `RCR_ZERO_BYTE)
        else $error("forced reset left flags set");
    a_user_write_ignored: assert property (@(posedge sys_clk) disable iff (reset)
        reg_wr_en && !reg_wr_debug && !lvd_now && !any_now && !system_reset
        |=> !system_reset)
        else $error("user write forced a reset");
    a_pin_flag: assert property (@(posedge sys_clk) disable iff (reset)
        !system_reset && pin_now && !force_now && !lvd_now |=> cause.flags[`RCR_BIT_PIN])
        else $error("pin reset flag not set");
    a_stop_illegal: assert property (@(posedge sys_clk) disable iff (reset)
        !system_reset && stop_exec && !stop_enable && !force_now && !lvd_now
        |=> system_reset && cause.flags[`RCR_BIT_ILLEGAL_OPCODE_FLAG])
        else $error("disabled stop did not reset");
    a_background_entry_instruction_illegal: assert property (@(posedge sys_clk) disable iff (reset)
        !system_reset && background_entry_instruction && !background_mode_enable
        && !force_now && !lvd_now |=> cause.flags[`RCR_BIT_ILLEGAL_OPCODE_FLAG])
        else $error("disabled background entry not illegal");
    a_mode_select: assert property (@(posedge sys_clk) disable iff (reset)
        system_reset && forced_reg && state_next == ST_RUN
        |=> debug_halt_mode == $past(~pin_sync_reg[1]))
        else $error("mode pin not applied after forced reset");

    c_forced_reset: cover property (@(posedge sys_clk) force_now && !system_reset);
    c_lvd_reset: cover property (@(posedge sys_clk) lvd_now && !system_reset);
    c_debug_entry: cover property (@(posedge sys_clk) $rose(debug_halt_mode));
    c_wd_restart: cover property (@(posedge sys_clk) watchdog_restart);
endmodule

//--- test/debug_host_model.sv
// Model of the external debug host on the serial background link.
// Assumes the bench merges its write strobe onto the register port.
module debug_host_model (
    input wire logic sys_clk,
    output logic host_wr,
    output logic [7:0] host_addr,
    output logic [7:0] host_data,
    output logic mode_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle host keeps the mode pin high, which selects user mode
    initial begin
        host_wr = 1'b0;
        host_addr = 8'h00;
        host_data = 8'h00;
        mode_pin = 1'b1;
    end

    // One byte write of the forced reset bit, then the mode level
    task automatic force_reset(input logic user_mode);
        @(posedge sys_clk);
        #1;
        host_wr = 1'b1;
        host_addr = 8'h01;
        host_data = 8'h01;
        @(posedge sys_clk);
        #1;
        host_wr = 1'b0;
        // Released lines drift away from the last value
        host_addr = ~host_addr;
        host_data = ~host_data;
        mode_pin = user_mode;
    endtask
endmodule

//--- test/rcr_top_tb.sv
// Self-checking bench for the reset cause block.
// Assumes the debug host model sits beside it and shares the register port.
`include "rcr_params.svh"

module rcr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rcr_pkg::*;

    logic sys_clk, reset, tb_wr, reg_rd_en, host_wr, mode_pin;
    logic [7:0] tb_addr, host_addr, host_data, reg_rd_data;
    byte_t tb_data;
    logic reset_pin_n, low_voltage_trip, low_voltage_reset_enable, watchdog_timeout;
    logic watchdog_enable, illegal_opcode_exec, stop_exec, stop_enable;
    logic background_entry_instruction, background_mode_enable, illegal_address_access;
    logic system_reset, watchdog_restart, debug_halt_mode;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    // Cause table: source bits pin, wdog, illegal_opcode_flag, stop, background_entry_instruction, illegal_address_flag, lvd
    logic [6:0] c_src [7] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h22};
    logic [7:0] c_exp [7] = '{8'h40, 8'h20, 8'h10, 8'h10, 8'h10, 8'h08, 8'h28};

    rcr_top u_dut (.sys_clk(sys_clk), .reset(reset), .reg_wr_en(tb_wr | host_wr),
        .reg_rd_en(reg_rd_en), .reg_wr_debug(host_wr),
        .reg_addr(host_wr ? host_addr : tb_addr),
        .reg_wr_data(host_wr ? host_data : tb_data), .reg_rd_data(reg_rd_data),
        .reset_pin_n(reset_pin_n), .low_voltage_trip(low_voltage_trip),
        .low_voltage_reset_enable(low_voltage_reset_enable),
        .watchdog_timeout(watchdog_timeout), .watchdog_enable(watchdog_enable),
        .illegal_opcode_exec(illegal_opcode_exec), .stop_exec(stop_exec),
        .stop_enable(stop_enable),
        .background_entry_instruction(background_entry_instruction),
        .background_mode_enable(background_mode_enable),
        .illegal_address_access(illegal_address_access),
        .background_mode_select_pin(mode_pin), .system_reset(system_reset),
        .watchdog_restart(watchdog_restart), .debug_halt_mode(debug_halt_mode));

    debug_host_model u_host (.sys_clk(sys_clk), .host_wr(host_wr), .host_addr(host_addr),
        .host_data(host_data), .mode_pin(mode_pin));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; the whole run needs well under a thousand cycles
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        forever begin
            @(posedge sys_clk);
            cycles++;
            if (cycles == 3000) begin
                num_errors++;
                $display("wrong value at %0t: run timed out", $time);
                results();
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        #1;
        reset = 1'b1;
        repeat (8) @(posedge sys_clk);
        #1;
        reset = 1'b0;
    endtask

    // Read strobe for one edge; data stands in the following cycle only
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_rd_en = 1'b1;
        tb_addr = a;
        @(posedge sys_clk);
        #1;
        reg_rd_en = 1'b0;
        d = reg_rd_data;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic rs);
        @(posedge sys_clk);
        #1;
        tb_wr = 1'b1;
        tb_addr = a;
        tb_data = v;
        @(posedge sys_clk);
        #1;
        tb_wr = 1'b0;
        rs = watchdog_restart;
    endtask

    // Bounded wait for entry, then count the cycles the chip reset stands
    task automatic wait_reset(output int n);
        n = 0;
        for (int i = 0; i < 20 && system_reset !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        while (system_reset === 1'b1 && n < 60) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_por();
        logic [7:0] d;
        rd(`RCR_OFF_STATUS, d);
        check(d, 8'h82, "flags after power-on");
        rd(8'h7f, d);
        check(d, 8'h00, "unmapped read");
        $display("test por done");
    endtask

    task automatic t_status_write();
        logic rs;
        logic [7:0] d;
        wr(`RCR_OFF_STATUS, 8'h7d, rs);
        check(rs, 1'b1, "watchdog restart");
        rd(`RCR_OFF_STATUS, d);
        check(d, 8'h82, "flags after status write");
        $display("test status write done");
    endtask

    // A user program write of the forced bit must not reset the chip
    task automatic t_user_force();
        logic rs;
        logic [7:0] d;
        wr(`RCR_OFF_FORCE, 8'hff, rs);
        repeat (3) @(posedge sys_clk);
        #1;
        check(system_reset, 1'b0, "user forced write");
        rd(`RCR_OFF_FORCE, d);
        check(d, 8'h00, "forced register read");
        $display("test user force done");
    endtask

    task automatic t_forced(input logic user_mode);
        int n;
        logic [7:0] d;
        u_host.force_reset(user_mode);
        check(system_reset, 1'b1, "forced reset entry");
        wait_reset(n);
        check(n == `RCR_HOLD_CYC, 1'b1, "forced hold length");
        check(debug_halt_mode, !user_mode, "mode after forced reset");
        rd(`RCR_OFF_STATUS, d);
        check(d, 8'h00, "flags after forced reset");
        $display("test forced reset done");
    endtask

    // Sources held three edges so the synced pin is seen too; a fast source
    // has the chip reset standing already, so those edges count toward it
    task automatic t_cause(input logic [6:0] src, input logic [7:0] exp);
        int n;
        int m;
        logic [7:0] d;
        @(posedge sys_clk);
        #1;
        reset_pin_n = ~src[0];
        {low_voltage_trip, illegal_address_access, background_entry_instruction} = src[6:4];
        {stop_exec, illegal_opcode_exec, watchdog_timeout} = src[3:1];
        n = 0;
        repeat (2) begin
            @(posedge sys_clk);
            #1;
            n += (system_reset === 1'b1) ? 1 : 0;
        end
        @(posedge sys_clk);
        #1;
        reset_pin_n = 1'b1;
        {low_voltage_trip, illegal_address_access, background_entry_instruction} = 3'h0;
        {stop_exec, illegal_opcode_exec, watchdog_timeout} = 3'h0;
        wait_reset(m);
        check(n + m >= `RCR_HOLD_CYC, 1'b1, "source hold length");
        rd(`RCR_OFF_STATUS, d);
        rd(`RCR_OFF_STATUS, d);
        check(d, exp, "flags after source reset");
        $display("test cause %h done", src);
    endtask

    // Disabled sources and legal stop or background entry cause nothing
    task automatic t_blocked();
        logic [7:0] d;
        {watchdog_enable, stop_enable, background_mode_enable} = 3'h3;
        low_voltage_reset_enable = 1'b0;
        {watchdog_timeout, stop_exec, background_entry_instruction} = 3'h7;
        low_voltage_trip = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        check(system_reset, 1'b0, "blocked sources");
        {watchdog_timeout, stop_exec, background_entry_instruction} = 3'h0;
        low_voltage_trip = 1'b0;
        {watchdog_enable, stop_enable, background_mode_enable} = 3'h4;
        low_voltage_reset_enable = 1'b1;
        rd(`RCR_OFF_STATUS, d);
        check(d, 8'h28, "flags kept while blocked");
        $display("test blocked done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {reset, tb_wr, reg_rd_en, tb_addr, tb_data} = {1'b1, 1'b0, 1'b0, 8'h00, 8'h00};
        {reset_pin_n, low_voltage_trip, low_voltage_reset_enable} = 3'h5;
        {watchdog_timeout, watchdog_enable, illegal_opcode_exec, stop_exec} = 4'h4;
        {stop_enable, background_entry_instruction, background_mode_enable} = 3'h0;
        illegal_address_access = 1'b0;
        do_reset();
        t_por();
        t_status_write();
        t_user_force();
        t_forced(1'b0);
        t_forced(1'b1);
        for (int i = 0; i < 7; i++) begin
            t_cause(c_src[i], c_exp[i]);
        end
        t_blocked();
        t_cause(7'h40, 8'h02);
        do_reset();
        t_cause(7'h40, 8'h82);
        results();
    end

    task automatic results();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
endmodule
